// >>> smad_top.sv
`timescale 1ns/1ns
// Purpose: management memory access decoder between host bus and the
//          DRAM and PCI forwarding paths
// Assumes: host and initiator inputs synchronous to CORE_CLK
// Notes:   one decision per strobe; back to back strobes are allowed
//
// Operation
// - open, closed and lock have no effect unless global enable is set
// - open with lock clear makes management memory visible without active
// - closed sends data accesses to PCI; code fetches still reach DRAM
// - writing lock forces open to 0; both then read-only
// - lock set by a write, cleared only by power-on reset
// - global enable exposes 128 KB DRAM at A0000h to active cycles
// - extended regions claimed only with global enable and own enable
// - base segment field fixed at 010, A0000-BFFFFh, not writable
// - no remapping; address passes unchanged to DRAM or PCI
// - PCI initiators never reach management memory in DRAM
// - A segment needs high enable 0; high region needs it 1; top its own
// - all regions to PCI if global off, or inactive with open clear
// - top segment decodes only with global and segment enable set
// - high enable lets the high region appear at its addresses
module smad_top
    import smad_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RSTN,
    input  wire logic        CFG_WR,
    input  wire logic        CFG_RD,
    input  wire logic [7:0]  CFG_ADDR,
    input  wire logic [7:0]  CFG_WDATA,
    output logic      [7:0]  CFG_RDATA,
    input  wire logic        ADDRESS_STROBE_N,
    input  wire logic        MGMT_MODE_ACTIVE_N,
    input  wire logic [31:0] HOST_ADDR,
    input  wire logic        CODE_FETCH,
    input  wire logic        HIGH_REGION_ENABLE,
    input  wire logic        TOP_SEG_ENABLE,
    input  wire logic [1:0]  TOP_SEG_SIZE,
    input  wire logic [31:0] TOP_OF_MEM,
    input  wire logic        PCI_REQ_VALID,
    input  wire logic [31:0] PCI_REQ_ADDR,
    output logic             ROUTE_VALID,
    output logic             ROUTE_TO_DRAM,
    output logic             ROUTE_TO_PCI,
    output logic [31:0]      ROUTE_ADDR,
    output logic [1:0]       ROUTE_REGION,
    output logic             ROUTE_INVALID,
    output logic             PCI_RESULT_VALID,
    output logic             PCI_DRAM_DENY
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_OUT  = 2'h1
    } smad_state_e;

    typedef struct packed {
        smad_state_e state;
        logic        to_dram;
        logic [31:0] addr;
        logic [1:0]  region;
        logic        invalid;
        logic        pci_valid;
        logic        pci_deny;
    } smad_top_s;

    smad_top_s    state_ff;
    smad_top_s    nxt_state;
    smad_region_e host_region;
    smad_region_e pci_region;
    logic         host_to_dram;
    logic         host_invalid;
    logic         strobe;

    smad_ctl_if ctl ();

    smad_cfg_regs u_regs (
        .clk       (CORE_CLK),
        .rst_n     (RSTN),
        .cfg_wr    (CFG_WR),
        .cfg_rd    (CFG_RD),
        .cfg_addr  (CFG_ADDR),
        .cfg_wdata (CFG_WDATA),
        .cfg_rdata (CFG_RDATA),
        .ctl       (ctl.regs)
    );

    // active indication is taken in the same cycle as the strobe
    smad_route u_route (
        .ctl                (ctl.route),
        .addr               (HOST_ADDR),
        .code_fetch         (CODE_FETCH),
        .mgmt_mode_active_n (MGMT_MODE_ACTIVE_N),
        .high_region_enable (HIGH_REGION_ENABLE),
        .top_seg_enable     (TOP_SEG_ENABLE),
        .top_of_mem         (TOP_OF_MEM),
        .top_seg_size_sel   (TOP_SEG_SIZE),
        .region             (host_region),
        .to_dram            (host_to_dram),
        .invalid            (host_invalid)
    );

    always_comb begin
        strobe     = ~ADDRESS_STROBE_N;
        pci_region = region_of(PCI_REQ_ADDR, TOP_OF_MEM, TOP_SEG_SIZE);
        nxt_state  = state_ff;
        nxt_state.pci_valid = PCI_REQ_VALID;
        // initiators are kept out of every region, whatever the setup
        nxt_state.pci_deny  = PCI_REQ_VALID
                              & (pci_region != RGN_NONE);
        unique case (state_ff.state)
            ST_IDLE: begin
                if (strobe) begin
                    nxt_state.state = ST_OUT;
                end
            end
            ST_OUT: begin
                if (!strobe) begin
                    nxt_state.state = ST_IDLE;
                end
            end
            default: begin
                nxt_state.state = ST_IDLE;
            end
        endcase
        if (strobe) begin
            nxt_state.to_dram = host_to_dram;
            nxt_state.addr    = HOST_ADDR;
            nxt_state.region  = host_region;
            nxt_state.invalid = host_invalid;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_ff <= '{state: ST_IDLE, addr: '0, region: RGN_NONE,
                          default: 1'b0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign ROUTE_VALID      = (state_ff.state == ST_OUT);
    assign ROUTE_TO_DRAM    = state_ff.to_dram;
    assign ROUTE_TO_PCI     = ~state_ff.to_dram;
    assign ROUTE_ADDR       = state_ff.addr;
    assign ROUTE_REGION     = state_ff.region;
    assign ROUTE_INVALID    = state_ff.invalid;
    assign PCI_RESULT_VALID = state_ff.pci_valid;
    assign PCI_DRAM_DENY    = state_ff.pci_deny;

endmodule

// >>> smad_pkg.sv
// Purpose: constants, types and decode functions for the management
//          memory access decoder
// Assumes: 32-bit host and initiator addresses, 8-bit configuration data
// Notes:   region limits are inclusive byte addresses
package smad_pkg;

    localparam logic [7:0]  CFG_OFS_MGMT_RAM_CONTROL = 8'h72;
    localparam logic [7:0]  MGMT_RAM_CONTROL_RESET   = 8'h02;
    localparam logic [7:0]  CFG_UNMAPPED_READ        = 8'h00;

    localparam int          BIT_RESERVED             = 7;
    localparam int          BIT_SPACE_OPEN           = 6;
    localparam int          BIT_SPACE_CLOSED         = 5;
    localparam int          BIT_SPACE_LOCK           = 4;
    localparam int          BIT_GLOBAL_ENABLE        = 3;
    localparam int          SEG_LSB                  = 0;
    localparam int          SEG_MSB                  = 2;
    localparam logic [2:0]  COMPAT_BASE_SEGMENT      = 3'h2;

    localparam logic [31:0] A_SEG_BASE               = 32'h000a_0000;
    localparam logic [31:0] A_SEG_LAST               = 32'h000b_ffff;
    localparam logic [31:0] HIGH_REGION_BASE         = 32'h100a_0000;
    localparam logic [31:0] HIGH_REGION_LAST         = 32'h100f_ffff;
    localparam logic [31:0] TOP_SEG_OFFSET           = 32'h1000_0000;
    localparam logic [31:0] TOP_SEG_128K             = 32'h0002_0000;
    localparam logic [31:0] TOP_SEG_256K             = 32'h0004_0000;
    localparam logic [31:0] TOP_SEG_512K             = 32'h0008_0000;
    localparam logic [31:0] TOP_SEG_1M               = 32'h0010_0000;
    localparam logic [31:0] ONE_BYTE                 = 32'h0000_0001;

    typedef enum logic [1:0] {
        RGN_NONE = 2'h0,
        RGN_A    = 2'h1,
        RGN_HIGH = 2'h3,
        RGN_TOP  = 2'h2
    } smad_region_e;

    function automatic logic [31:0] top_seg_size(input logic [1:0] sel);
        unique case (sel)
            2'h0: top_seg_size = TOP_SEG_128K;
            2'h1: top_seg_size = TOP_SEG_256K;
            2'h2: top_seg_size = TOP_SEG_512K;
            2'h3: top_seg_size = TOP_SEG_1M;
        endcase
    endfunction

    // used for host cycles and initiator cycles alike
    function automatic smad_region_e region_of(input logic [31:0] addr,
                                               input logic [31:0] tom,
                                               input logic [1:0]  tsz);
        logic [31:0] top_end;
        logic [31:0] top_base;
        top_end  = TOP_SEG_OFFSET + tom;
        top_base = top_end - top_seg_size(tsz);
        if (addr >= A_SEG_BASE && addr <= A_SEG_LAST) begin
            region_of = RGN_A;
        end else if (addr >= HIGH_REGION_BASE && addr <= HIGH_REGION_LAST)
        begin
            region_of = RGN_HIGH;
        end else if (addr >= top_base && addr <= top_end - ONE_BYTE) begin
            region_of = RGN_TOP;
        end else begin
            region_of = RGN_NONE;
        end
    endfunction

endpackage

// >>> smad_ctl_if.sv
`timescale 1ns/1ns
// Purpose: carries the control bits from the register file to the router
// Assumes: single clock domain
// Notes:   open is already forced low while lock is set
interface smad_ctl_if;
    logic space_open;
    logic space_closed;
    logic space_lock;
    logic global_mgmt_ram_enable;

    modport regs  (output space_open, space_closed, space_lock,
                   global_mgmt_ram_enable);
    modport route (input  space_open, space_closed, space_lock,
                   global_mgmt_ram_enable);
endinterface

// >>> smad_cfg_regs.sv
`timescale 1ns/1ns
// Purpose: management memory control register at configuration offset 72h
// Assumes: one write or read request per cycle, synchronous to clk
// Notes:   read data is registered, one cycle after the read request
module smad_cfg_regs
    import smad_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       cfg_wr,
    input  wire logic       cfg_rd,
    input  wire logic [7:0] cfg_addr,
    input  wire logic [7:0] cfg_wdata,
    output logic      [7:0] cfg_rdata,
    smad_ctl_if.regs        ctl
);

    typedef struct packed {
        logic       open;
        logic       closed;
        logic       lock;
        logic       global_en;
        logic [7:0] rdata;
    } smad_regs_s;

    smad_regs_s state_ff;
    smad_regs_s nxt_state;
    logic [7:0] reg_view;
    logic       hit;

    always_comb begin
        reg_view = '0;
        reg_view[BIT_RESERVED]      = 1'b0;
        reg_view[BIT_SPACE_OPEN]    = state_ff.open;
        reg_view[BIT_SPACE_CLOSED]  = state_ff.closed;
        reg_view[BIT_SPACE_LOCK]    = state_ff.lock;
        reg_view[BIT_GLOBAL_ENABLE] = state_ff.global_en;
        reg_view[SEG_MSB:SEG_LSB]   = COMPAT_BASE_SEGMENT;
        hit = (cfg_addr == CFG_OFS_MGMT_RAM_CONTROL);
        nxt_state = state_ff;
        if (cfg_wr && hit) begin
            nxt_state.closed    = cfg_wdata[BIT_SPACE_CLOSED];
            nxt_state.global_en = cfg_wdata[BIT_GLOBAL_ENABLE];
            // lock is sticky until power-on reset: a 0 is ignored
            nxt_state.lock = state_ff.lock | cfg_wdata[BIT_SPACE_LOCK];
            if (nxt_state.lock) begin
                nxt_state.open = 1'b0;
            end else begin
                nxt_state.open = cfg_wdata[BIT_SPACE_OPEN];
            end
        end
        if (cfg_rd) begin
            nxt_state.rdata = hit ? reg_view : CFG_UNMAPPED_READ;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff.open      <= MGMT_RAM_CONTROL_RESET[BIT_SPACE_OPEN];
            state_ff.closed    <= MGMT_RAM_CONTROL_RESET[BIT_SPACE_CLOSED];
            state_ff.lock      <= MGMT_RAM_CONTROL_RESET[BIT_SPACE_LOCK];
            state_ff.global_en <= MGMT_RAM_CONTROL_RESET[BIT_GLOBAL_ENABLE];
            state_ff.rdata     <= CFG_UNMAPPED_READ;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign cfg_rdata                  = state_ff.rdata;
    assign ctl.space_open             = state_ff.open;
    assign ctl.space_closed           = state_ff.closed;
    assign ctl.space_lock             = state_ff.lock;
    assign ctl.global_mgmt_ram_enable = state_ff.global_en;

endmodule

// >>> smad_route.sv
`timescale 1ns/1ns
// Purpose: combinational DRAM or PCI decision for one host cycle
// Assumes: inputs are stable in the strobe cycle
// Notes:   addresses are never altered, only the target is chosen
module smad_route
    import smad_pkg::*;
(
    smad_ctl_if.route          ctl,
    input  wire logic [31:0]   addr,
    input  wire logic          code_fetch,
    input  wire logic          mgmt_mode_active_n,
    input  wire logic          high_region_enable,
    input  wire logic          top_seg_enable,
    input  wire logic [31:0]   top_of_mem,
    input  wire logic [1:0]    top_seg_size_sel,
    output smad_region_e       region,
    output logic               to_dram,
    output logic               invalid
);

    logic g;
    logic eff_open;
    logic eff_closed;
    logic eff_lock;
    logic visible;
    logic claim;

    always_comb begin
        g          = ctl.global_mgmt_ram_enable;
        eff_open   = g & ctl.space_open;
        eff_closed = g & ctl.space_closed;
        eff_lock   = g & ctl.space_lock;
        region     = region_of(addr, top_of_mem, top_seg_size_sel);
        // open with lock clear stands in for the active indication
        visible    = g & (~mgmt_mode_active_n
                          | (eff_open & ~eff_lock));
        // both open and closed set is not a legal setup: send to PCI
        invalid    = eff_open & eff_closed;
        unique case (region)
            RGN_A:    claim = visible & ~high_region_enable;
            RGN_HIGH: claim = visible & high_region_enable;
            RGN_TOP:  claim = visible & g & top_seg_enable;
            RGN_NONE: claim = 1'b0;
        endcase
        // closed keeps data away from DRAM, code still reaches it
        to_dram = claim & ~invalid
                  & (code_fetch | ~eff_closed);
    end

endmodule

// >>> smad_top_props.sv
// Purpose: port checker for the management memory access decoder
// Assumes: one clock domain, reset asynchronous and active low
// Notes:   sees only top-level ports, so register state is not visible
`timescale 1ns/1ns
module smad_top_props
    import smad_pkg::*;
(
    input wire logic        CORE_CLK,
    input wire logic        RSTN,
    input wire logic        CFG_RD,
    input wire logic [7:0]  CFG_ADDR,
    input wire logic [7:0]  CFG_RDATA,
    input wire logic        ADDRESS_STROBE_N,
    input wire logic [31:0] HOST_ADDR,
    input wire logic        HIGH_REGION_ENABLE,
    input wire logic        PCI_REQ_VALID,
    input wire logic [31:0] PCI_REQ_ADDR,
    input wire logic        ROUTE_VALID,
    input wire logic        ROUTE_TO_DRAM,
    input wire logic        ROUTE_TO_PCI,
    input wire logic [31:0] ROUTE_ADDR,
    input wire logic [1:0]  ROUTE_REGION,
    input wire logic        ROUTE_INVALID,
    input wire logic        PCI_RESULT_VALID,
    input wire logic        PCI_DRAM_DENY
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    a_valid_follows:
        assert property (ROUTE_VALID == !$past(ADDRESS_STROBE_N))
        else $error("route result not one cycle after strobe");
    a_addr_unchanged:
        assert property (!ADDRESS_STROBE_N |=> ROUTE_ADDR == $past(HOST_ADDR))
        else $error("routed address differs from strobed address");
    a_pci_inverse:
        assert property (ROUTE_TO_PCI != ROUTE_TO_DRAM)
        else $error("pci and dram targets not exclusive");
    a_invalid_to_pci:
        assert property (ROUTE_INVALID |-> ROUTE_TO_PCI)
        else $error("invalid combination reached dram");
    a_none_to_pci:
        assert property (ROUTE_REGION == RGN_NONE |-> ROUTE_TO_PCI)
        else $error("address outside regions reached dram");
    a_high_needs_en:
        assert property (ROUTE_VALID && ROUTE_TO_DRAM &&
            ROUTE_REGION == RGN_HIGH |-> $past(HIGH_REGION_ENABLE))
        else $error("high region claimed with its enable off");
    a_seg_a_high_off:
        assert property (ROUTE_VALID && ROUTE_TO_DRAM &&
            ROUTE_REGION == RGN_A |-> !$past(HIGH_REGION_ENABLE))
        else $error("segment A claimed with high enable on");
    a_deny_seg_a:
        assert property (PCI_REQ_VALID && PCI_REQ_ADDR >= A_SEG_BASE &&
            PCI_REQ_ADDR <= A_SEG_LAST |=> PCI_RESULT_VALID && PCI_DRAM_DENY)
        else $error("initiator not denied segment A");
    a_fixed_bits:
        assert property (CFG_RD && CFG_ADDR == CFG_OFS_MGMT_RAM_CONTROL |=>
            !CFG_RDATA[7] && CFG_RDATA[2:0] == COMPAT_BASE_SEGMENT)
        else $error("fixed control bits read wrong");
endmodule

// >>> smad_host_bfm.sv
// Purpose: host bus model issuing code and data cycles
// Assumes: one call per clock, changes land just after the rising edge
// Notes:   idle cycles show the inverted address so stale values never match
`timescale 1ns/1ns
module smad_host_bfm (
    input  wire logic  clk,
    output logic       strobe_n,
    output logic       active_n,
    output logic       code,
    output logic [31:0] addr
);
    initial begin
        strobe_n = 1'b1;
        active_n = 1'b1;
        code = 1'b0;
        addr = 32'h0000_0000;
    end
    task automatic issue(input logic go, input logic [31:0] a,
                         input logic c, input logic act_n);
        @(posedge clk);
        strobe_n <= !go;
        addr <= go ? a : ~addr;
        code <= go ? c : ~code;
        active_n <= act_n;
    endtask
endmodule

// >>> smad_top_tb.sv
// Purpose: self-checking bench for the management memory access decoder
// Assumes: expectations come from a shadow of the control register
// Notes:   register traffic, host cycles and initiator cycles run mixed
`timescale 1ns/1ns
module smad_top_tb
    import smad_pkg::*;
;
    localparam logic [31:0] top_mem = 32'h0080_0000;
    logic        clk = 1'b0, rstn = 1'b0, rd_pend = 1'b0;
    logic        cfg_wr = 1'b0, cfg_rd = 1'b0, hi = 1'b0, te = 1'b0;
    logic [7:0]  cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata;
    logic        strobe_n, active_n, code, pv = 1'b0;
    logic [1:0]  tsz = 2'h0, r_rgn;
    logic [31:0] host_addr, pa = 32'h0000_0000, r_addr;
    logic        r_valid, r_dram, r_pci, r_inv, p_valid, p_deny;
    logic        s_open, s_cls, s_lck, s_g;
    logic [35:0] rq[$];
    logic [7:0]  cq[$];
    logic        dq[$];
    int          n_mismatch = 0, check_count = 0, seed = 32'h5a623d0a;
    smad_host_bfm host (.clk(clk), .strobe_n(strobe_n),
        .active_n(active_n), .code(code), .addr(host_addr));
    smad_top DUT (.CORE_CLK(clk), .RSTN(rstn), .CFG_WR(cfg_wr),
        .CFG_RD(cfg_rd), .CFG_ADDR(cfg_addr), .CFG_WDATA(cfg_wdata),
        .CFG_RDATA(cfg_rdata), .ADDRESS_STROBE_N(strobe_n),
        .MGMT_MODE_ACTIVE_N(active_n), .HOST_ADDR(host_addr),
        .CODE_FETCH(code), .HIGH_REGION_ENABLE(hi), .TOP_SEG_ENABLE(te),
        .TOP_SEG_SIZE(tsz), .TOP_OF_MEM(top_mem), .PCI_REQ_VALID(pv),
        .PCI_REQ_ADDR(pa), .ROUTE_VALID(r_valid), .ROUTE_TO_DRAM(r_dram),
        .ROUTE_TO_PCI(r_pci), .ROUTE_ADDR(r_addr), .ROUTE_REGION(r_rgn),
        .ROUTE_INVALID(r_inv), .PCI_RESULT_VALID(p_valid),
        .PCI_DRAM_DENY(p_deny));
    always #50 clk = ~clk;
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    function automatic logic exp_dram(input logic [1:0] r, input logic c,
        input logic an, input logic h, input logic t);
        logic vis;
        vis = s_g
              & (!an | (s_open & !s_lck));
        if (s_g & s_open & s_cls) return 1'b0;
        if (s_g & s_cls & !c) return 1'b0;
        case (r)
            RGN_A: return vis & !h;
            RGN_HIGH: return vis & h;
            RGN_TOP: return vis & t;
            default: return 1'b0;
        endcase
    endfunction
    function automatic logic [33:0] pick(input logic [2:0] k,
        input logic [1:0] sz);
        logic [31:0] e;
        e = TOP_SEG_OFFSET + top_mem;
        case (k)
            3'h0: return {RGN_A, A_SEG_BASE};
            3'h1: return {RGN_A, A_SEG_LAST};
            3'h2: return {RGN_HIGH, HIGH_REGION_BASE};
            3'h3: return {RGN_HIGH, HIGH_REGION_LAST};
            3'h4: return {RGN_TOP, e - 32'h0000_0001};
            3'h5: return {RGN_TOP, e - (32'h0002_0000 << sz)};
            3'h6: return {RGN_NONE, A_SEG_BASE - 32'h0000_0001};
            default: return {RGN_NONE, e};
        endcase
    endfunction
    function automatic logic [7:0] shadow_rd();
        return {1'b0, s_open, s_cls, s_lck, s_g, COMPAT_BASE_SEGMENT};
    endfunction
    task automatic shadow_wr(input logic [7:0] d);
        if (!s_lck) s_open = d[6];
        s_cls = d[5];
        s_g = d[3];
        s_lck = s_lck | d[4];
        if (s_lck) s_open = 1'b0;
    endtask
    task automatic rd72();
        @(posedge clk);
        cfg_rd <= 1'b1;
        cfg_addr <= CFG_OFS_MGMT_RAM_CONTROL;
        cq.push_back(shadow_rd());
    endtask
    task automatic drain();
        host.issue(1'b0, 32'h0000_0000, 1'b0, 1'b1);
        pv <= 1'b0;
        cfg_rd <= 1'b0;
        cfg_wr <= 1'b0;
        repeat (3) @(posedge clk);
        check(36'(rq.size() + cq.size() + dq.size()), 36'h0);
    endtask
    always @(posedge clk) rd_pend <= cfg_rd;
    always @(negedge clk) begin
        logic [35:0] e;
        e = 'x;
        if (r_valid === 1'b1) begin
            e = rq.size() ? rq.pop_front() : 'x;
            check({r_inv, r_dram, r_rgn, r_addr}, e);
            check(36'(r_pci), 36'(!e[34]));
        end
        if (p_valid === 1'b1) begin
            e = dq.size() ? 36'(dq.pop_front()) : 'x;
            check(36'(p_deny), e);
        end
        if (rd_pend === 1'b1) begin
            e = cq.size() ? 36'(cq.pop_front()) : 'x;
            check(36'(cfg_rdata), e);
        end
    end
    initial begin
        logic [31:0] rv, a, b;
        logic [1:0]  r, pr;
        logic [7:0]  wd;
        {s_open, s_cls, s_lck, s_g} = 4'h0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        rd72();
        for (int i = 0; i < 400; i++) begin
            rv = $random(seed);
            {r, a} = pick(rv[16:14], rv[11:10]);
            {pr, b} = pick(rv[19:17], rv[11:10]);
            wd = rv[31:24] & (i < 300 ? 8'hef : 8'hff);
            if (wd[4]) wd[6] = 1'b0;
            host.issue(|rv[1:0], a, rv[2], rv[3]);
            if (|rv[1:0]) rq.push_back({s_g & s_open & s_cls,
                exp_dram(r, rv[2], rv[3], rv[8], rv[9]), r, a});
            hi <= rv[8];
            te <= rv[9];
            tsz <= rv[11:10];
            pv <= rv[4];
            pa <= b;
            if (rv[4]) dq.push_back(pr != RGN_NONE);
            cfg_rd <= rv[5];
            cfg_wr <= rv[7:6] == 2'h0;
            cfg_addr <= |rv[13:12] ? CFG_OFS_MGMT_RAM_CONTROL : 8'h70;
            cfg_wdata <= wd;
            if (rv[5]) cq.push_back(|rv[13:12] ? shadow_rd() : 8'h00);
            if (rv[7:6] == 2'h0 && |rv[13:12]) shadow_wr(wd);
        end
        drain();
        $display("test random routing done");
        @(posedge clk) rstn <= 1'b0;
        @(posedge clk) rstn <= 1'b1;
        {s_open, s_cls, s_lck, s_g} = 4'h0;
        rd72();
        drain();
        $display("test reset read done");
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
bind smad_top smad_top_props u_props (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
    .CFG_RD(CFG_RD), .CFG_ADDR(CFG_ADDR), .CFG_RDATA(CFG_RDATA),
    .ADDRESS_STROBE_N(ADDRESS_STROBE_N), .HOST_ADDR(HOST_ADDR),
    .HIGH_REGION_ENABLE(HIGH_REGION_ENABLE), .PCI_REQ_VALID(PCI_REQ_VALID),
    .PCI_REQ_ADDR(PCI_REQ_ADDR), .ROUTE_VALID(ROUTE_VALID),
    .ROUTE_TO_DRAM(ROUTE_TO_DRAM), .ROUTE_TO_PCI(ROUTE_TO_PCI),
    .ROUTE_ADDR(ROUTE_ADDR), .ROUTE_REGION(ROUTE_REGION),
    .ROUTE_INVALID(ROUTE_INVALID), .PCI_RESULT_VALID(PCI_RESULT_VALID),
    .PCI_DRAM_DENY(PCI_DRAM_DENY));
